// *** mse_pkg.sv ***
// ==========================================
// Shared types and constants
package mse_pkg;

	typedef enum logic [3:0] {
		OP_COPY,
		OP_IDLE,
		OP_PULL,
		OP_PUSH,
		OP_SUB_EXIT,
		OP_IRQ_EXIT,
		OP_SHL,
		OP_SHLC,
		OP_SHR
	} mse_op_e;

	typedef struct packed {
		mse_op_e op;
		logic byte_sz;
		logic [15:0] src;
		logic [15:0] dst;
	} mse_cmd_s;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} mse_flags_s;

	typedef struct packed {
		logic osc_disable_bit;
		logic core_halt_bit;
		logic global_irq_enable;
	} mse_mode_s;

	// ==========================================
	// Stack and address constants
	localparam logic [19:0] SP_STEP = 20'h00002;
	localparam logic [19:0] SP_RESET = 20'h00000;
	localparam logic [19:0] PC_RESET = 20'h00000;
	localparam logic [3:0] PC_HI_CLEAR = 4'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	// ==========================================
	// Signed-doubling overflow window
	localparam logic [15:0] SHL_OVF_W_LO = 16'h4000;
	localparam logic [15:0] SHL_OVF_W_HI = 16'hc000;
	localparam logic [7:0] SHL_OVF_B_LO = 8'h40;
	localparam logic [7:0] SHL_OVF_B_HI = 8'hc0;

	// ==========================================
	// Status word layout
	localparam int SR_C = 0;
	localparam int SR_Z = 1;
	localparam int SR_N = 2;
	localparam int SR_GIE = 3;
	localparam int SR_HALT = 4;
	localparam int SR_OSC = 5;
	localparam int SR_V = 8;
	localparam int SR_PC_LO = 12;
	localparam int SR_PC_HI = 15;
	localparam int WORD_MSB = 15;
	localparam int BYTE_MSB = 7;

endpackage

// *** mse_exec.sv ***
`timescale 1ns/1ps
module mse_exec
	import mse_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire mse_cmd_s cmd,
	output logic res_valid,
	output logic [15:0] res_data,
	output logic mem_req,
	output logic mem_we,
	output logic [19:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_ack,
	output logic [19:0] sp,
	output logic [19:0] pc,
	output mse_flags_s flags,
	output mse_mode_s mode
);

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PULL,
		ST_PUSH,
		ST_RET,
		ST_INTERRUPT_EXIT_SR,
		ST_INTERRUPT_EXIT_PC
	} mse_state_e;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	// ==========================================
	// Helpers
	function automatic logic [15:0] size_of(input logic [15:0] v, input logic b);
		size_of = b ? {BYTE_ZERO, v[7:0]} : v;
	endfunction

	function automatic logic msb_of(input logic [15:0] v, input logic b);
		msb_of = b ? v[BYTE_MSB] : v[WORD_MSB];
	endfunction

	function automatic logic shl_ovf(input logic [15:0] v, input logic b);
		if (b)
		begin
			shl_ovf = (v[7:0] >= SHL_OVF_B_LO) && (v[7:0] < SHL_OVF_B_HI);
		end
		else
		begin
			shl_ovf = (v >= SHL_OVF_W_LO) && (v < SHL_OVF_W_HI);
		end
	endfunction

	// ==========================================
	// State
	mse_state_e state, next_state;
	logic byte_q, next_byte_q;
	logic [3:0] pc_hi, next_pc_hi;
	logic [19:0] next_sp, next_pc;
	logic [15:0] next_res_data, next_wdata, wdata, shift_r;
	logic next_res_valid, shift_c, accept;
	mse_flags_s next_flags;
	mse_mode_s next_mode;

	assign cmd_ready = (state == ST_IDLE);
	assign accept = cmd_valid && cmd_ready;
	assign mem_req = (state != ST_IDLE);
	assign mem_we = (state == ST_PUSH);
	assign mem_addr = sp;
	assign mem_wdata = wdata;

	// ==========================================
	// Shifter, shared by the three shift ops
	always_comb
	begin
		shift_r = WORD_ZERO;
		shift_c = 1'b0;
		case (cmd.op)
			OP_SHL:
			begin
				shift_r = size_of({cmd.dst[14:0], 1'b0}, cmd.byte_sz);
				shift_c = msb_of(cmd.dst, cmd.byte_sz);
			end
			OP_SHLC:
			begin
				shift_r = size_of({cmd.dst[14:0], flags.c}, cmd.byte_sz);
				shift_c = msb_of(cmd.dst, cmd.byte_sz);
			end
			OP_SHR:
			begin
				if (cmd.byte_sz)
				begin
					shift_r = {BYTE_ZERO, cmd.dst[7], cmd.dst[7:1]};
				end
				else
				begin
					shift_r = {cmd.dst[15], cmd.dst[15:1]};
				end
				shift_c = cmd.dst[0];
			end
			default:
			begin
				shift_r = WORD_ZERO;
				shift_c = 1'b0;
			end
		endcase
	end

	// ==========================================
	// Sequencer and architectural state
	always_comb
	begin
		next_state = state;
		next_byte_q = byte_q;
		next_pc_hi = pc_hi;
		next_sp = sp;
		next_pc = pc;
		next_flags = flags;
		next_mode = mode;
		next_wdata = wdata;
		next_res_data = res_data;
		next_res_valid = 1'b0;
		case (state)
			ST_IDLE:
			begin
				if (accept)
				begin
					next_byte_q = cmd.byte_sz;
					case (cmd.op)
						OP_COPY:
						begin
							next_res_data = size_of(cmd.src, cmd.byte_sz);
							next_res_valid = 1'b1;
						end
						OP_SHL, OP_SHLC, OP_SHR:
						begin
							next_res_data = shift_r;
							next_res_valid = 1'b1;
							next_flags.c = shift_c;
							next_flags.n = msb_of(shift_r, cmd.byte_sz);
							next_flags.z = (shift_r == WORD_ZERO);
							if (cmd.op == OP_SHR)
							begin
								next_flags.v = 1'b0;
							end
							else
							begin
								next_flags.v = shl_ovf(cmd.dst, cmd.byte_sz);
							end
						end
						OP_PULL:
						begin
							next_state = ST_PULL;
						end
						OP_PUSH:
						begin
							next_sp = sp - SP_STEP;
							next_wdata = size_of(cmd.src, cmd.byte_sz);
							next_state = ST_PUSH;
						end
						OP_SUB_EXIT:
						begin
							next_state = ST_RET;
						end
						OP_IRQ_EXIT:
						begin
							next_state = ST_INTERRUPT_EXIT_SR;
						end
						default:
						begin
							// Idle: the constant generator swallows the write
							next_res_valid = 1'b0;
						end
					endcase
				end
			end
			ST_PULL:
			begin
				if (mem_ack)
				begin
					next_res_data = size_of(mem_rdata, byte_q);
					next_res_valid = 1'b1;
					next_sp = sp + SP_STEP;
					next_state = ST_IDLE;
				end
			end
			ST_PUSH:
			begin
				if (mem_ack)
				begin
					next_state = ST_IDLE;
				end
			end
			ST_RET:
			begin
				if (mem_ack)
				begin
					next_pc = {PC_HI_CLEAR, mem_rdata};
					next_sp = sp + SP_STEP;
					next_state = ST_IDLE;
				end
			end
			ST_INTERRUPT_EXIT_SR:
			begin
				if (mem_ack)
				begin
					next_flags.n = mem_rdata[SR_N];
					next_flags.z = mem_rdata[SR_Z];
					next_flags.c = mem_rdata[SR_C];
					next_flags.v = mem_rdata[SR_V];
					next_mode.osc_disable_bit = mem_rdata[SR_OSC];
					next_mode.core_halt_bit = mem_rdata[SR_HALT];
					next_mode.global_irq_enable = mem_rdata[SR_GIE];
					next_pc_hi = mem_rdata[SR_PC_HI:SR_PC_LO];
					next_sp = sp + SP_STEP;
					next_state = ST_INTERRUPT_EXIT_PC;
				end
			end
			ST_INTERRUPT_EXIT_PC:
			begin
				if (mem_ack)
				begin
					next_pc = {pc_hi, mem_rdata};
					next_sp = sp + SP_STEP;
					next_state = ST_IDLE;
				end
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			state <= ST_IDLE;
			byte_q <= 1'b0;
			pc_hi <= PC_HI_CLEAR;
			sp <= SP_RESET;
			pc <= PC_RESET;
			flags <= '0;
			mode <= '0;
			wdata <= WORD_ZERO;
			res_data <= WORD_ZERO;
			res_valid <= 1'b0;
		end
		else
		begin
			state <= next_state;
			byte_q <= next_byte_q;
			pc_hi <= next_pc_hi;
			sp <= next_sp;
			pc <= next_pc;
			flags <= next_flags;
			mode <= next_mode;
			wdata <= next_wdata;
			res_data <= next_res_data;
			res_valid <= next_res_valid;
		end
	end

	// ==========================================
	// Checks

	a_copy_keeps_flags: assert property (accept && cmd.op == OP_COPY |=>
		$stable(flags) && res_valid && res_data == $past(size_of(cmd.src, cmd.byte_sz)))
		else $error("copy result or flags wrong");
	a_idle_no_effect: assert property (accept && cmd.op == OP_IDLE |=>
		!res_valid && $stable(flags) && $stable(sp) && state == ST_IDLE)
		else $error("idle changed state");
	a_pull_step_two: assert property (state == ST_PULL && mem_ack |=>
		sp == $past(sp) + SP_STEP && res_valid && $stable(flags))
		else $error("pull did not advance by two");
	a_pull_byte_zero: assert property (state == ST_PULL && mem_ack && byte_q |=>
		res_data == {BYTE_ZERO, $past(mem_rdata[7:0])})
		else $error("byte pull upper byte not cleared");
	a_push_pre_dec: assert property (accept && cmd.op == OP_PUSH |=>
		sp == $past(sp) - SP_STEP && mem_we && mem_addr == sp)
		else $error("store did not predecrement");
	a_ret_clears_hi: assert property (state == ST_RET && mem_ack |=>
		pc == {PC_HI_CLEAR, $past(mem_rdata)} && sp == $past(sp) + SP_STEP)
		else $error("subroutine exit pc wrong");
	a_interrupt_exit_two_pulls: assert property (state == ST_INTERRUPT_EXIT_SR && mem_ack |=>
		state == ST_INTERRUPT_EXIT_PC && pc_hi == $past(mem_rdata[SR_PC_HI:SR_PC_LO]))
		else $error("interrupt exit sequence wrong");
	a_interrupt_exit_mode_load: assert property (state == ST_INTERRUPT_EXIT_SR && mem_ack |=>
		mode.global_irq_enable == $past(mem_rdata[SR_GIE]) && flags.v == $past(mem_rdata[SR_V]))
		else $error("status word not restored");
	a_mode_held: assert property (!(state == ST_INTERRUPT_EXIT_SR && mem_ack) |=> $stable(mode))
		else $error("mode bits changed");
	a_shl_word: assert property (accept && cmd.op == OP_SHL && !cmd.byte_sz |=>
		res_data == {$past(cmd.dst[14:0]), 1'b0} && flags.c == $past(cmd.dst[15]))
		else $error("shift left wrong");
	a_shlc_carry_in: assert property (accept && cmd.op == OP_SHLC && cmd.byte_sz |=>
		res_data[0] == $past(flags.c) && flags.c == $past(cmd.dst[7]) && res_data[15:8] == BYTE_ZERO)
		else $error("shift through carry wrong");
	a_shr_flags: assert property (accept && cmd.op == OP_SHR |=>
		!flags.v && flags.c == $past(cmd.dst[0]) && flags.z == (res_data == WORD_ZERO))
		else $error("shift right flags wrong");

	c_interrupt_exit_done: cover property (state == ST_INTERRUPT_EXIT_SR && mem_ack ##1 state == ST_INTERRUPT_EXIT_PC && mem_ack);
	c_byte_pull: cover property (state == ST_PULL && mem_ack && byte_q);
	c_shl_ovf: cover property (accept && cmd.op == OP_SHL ##1 flags.v);

endmodule

// *** mse_mem.sv ***
`timescale 1ns/1ps
// ==========
// Stack memory on the far side; dly delays the one-cycle answer
module mse_mem
	import mse_pkg::*;
(
	input wire logic clk_sys,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [19:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [3:0] dly,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	logic [15:0] mem [0:255];
	logic [15:0] rd = 16'h0;
	logic [3:0] cnt = 4'h0;
	initial mem_ack = 1'b0;
	// Outside an answer the data is inverted so a stale read cannot pass
	assign mem_rdata = mem_ack ? rd : ~rd;
	always @(posedge clk_sys)
	begin
		if (mem_ack && mem_req && mem_we)
			mem[mem_addr[8:1]] <= mem_wdata;
		if (mem_req && !mem_ack && cnt >= dly)
		begin
			mem_ack <= 1'b1;
			rd <= mem[mem_addr[8:1]];
			cnt <= 4'h0;
		end
		else
		begin
			mem_ack <= 1'b0;
			if (mem_req && !mem_ack)
				cnt <= cnt + 4'h1;
		end
	end
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top
	import mse_pkg::*;
;
	logic clk_sys, rst_n, cmd_valid, cmd_ready, res_valid, mem_req, mem_we, mem_ack;
	mse_cmd_s cmd;
	logic [15:0] res_data, mem_wdata, mem_rdata, s, w;
	logic [19:0] mem_addr, sp, pc, esp, epc, exp_r;
	mse_flags_s flags;
	mse_mode_s mode;
	logic [3:0] ef, dly;
	logic [2:0] emode;
	logic [19:0] q[$];
	int bad_count, check_count, i, j, b;
	mse_op_e ops[3] = '{OP_SHL, OP_SHLC, OP_SHR};
	logic [15:0] tv[10] = '{16'h4000, 16'h3fff, 16'hbfff, 16'hc000, 16'h0040, 16'h00c0,
		16'h003f, 16'h00bf, 16'h8000, 16'h0001};

	mse_exec uut (.clk_sys, .rst_n, .cmd_valid, .cmd_ready, .cmd, .res_valid, .res_data,
		.mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .sp, .pc, .flags, .mode);
	mse_mem mem_i (.clk_sys, .mem_req, .mem_we, .mem_addr, .mem_wdata, .dly, .mem_ack,
		.mem_rdata);

	always #50 clk_sys = ~clk_sys;

	// ==========
	// Checking
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Results off the queue: flags and data travel together
	task automatic compare_res(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task complete_run;
		$display("%0d checks, %0d mismatches", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(negedge clk_sys)
		if (rst_n === 1'b1 && res_valid === 1'b1)
		begin
			exp_r = q.size() > 0 ? q.pop_front() : 20'hxxxxx;
			compare_res({flags, res_data}, exp_r);
		end

	// ==========
	// Driving; a memory op blocks the next command until it is done
	task automatic send(input mse_op_e op, input logic b, input logic [15:0] s,
		input logic [15:0] d);
		@(negedge clk_sys);
		while (cmd_ready !== 1'b1)
		begin
			cmd_valid = 1'b0;
			@(negedge clk_sys);
		end
		cmd_valid = 1'b1;
		cmd = '{op, b, s, d};
	endtask

	task automatic settle;
		@(negedge clk_sys);
		cmd_valid = 1'b0;
		while (cmd_ready !== 1'b1)
			@(negedge clk_sys);
		repeat (2) @(negedge clk_sys);
		compare(32'({mode, pc}), 32'({emode, epc}));
		compare(32'(sp), 32'(esp));
		compare(32'(flags), 32'(ef));
		compare(32'(q.size()), 32'h0);
	endtask

	// Expectations are taken after send so a prior store has landed
	task automatic run(input mse_op_e op, input int b, input logic [15:0] s,
		input logic [15:0] d);
		int k;
		logic [15:0] r, x;
		send(op, b[0], s, d);
		k = b ? BYTE_MSB : WORD_MSB;
		x = b ? {8'h00, d[7:0]} : d;
		r = b ? {8'h00, mem_i.mem[esp[8:1]][7:0]} : mem_i.mem[esp[8:1]];
		case (op)
			OP_COPY: q.push_back({ef, b ? {8'h00, s[7:0]} : s});
			OP_PULL:
			begin
				q.push_back({ef, r});
				esp = esp + 20'h2;
			end
			OP_PUSH: esp = esp - 20'h2;
			OP_SUB_EXIT:
			begin
				epc = {4'h0, mem_i.mem[esp[8:1]]};
				esp = esp + 20'h2;
			end
			OP_IRQ_EXIT:
			begin
				w = mem_i.mem[esp[8:1]];
				ef = {w[SR_N], w[SR_Z], w[SR_C], w[SR_V]};
				emode = {w[SR_OSC], w[SR_HALT], w[SR_GIE]};
				epc = {w[15:12], mem_i.mem[esp[8:1] + 8'h1]};
				esp = esp + 20'h4;
			end
			OP_SHR:
			begin
				r = (x >> 1) | (x & (16'h1 << k));
				ef = {r[k], r == 16'h0, x[0], 1'b0};
				q.push_back({ef, r});
			end
			OP_SHL, OP_SHLC:
			begin
				r = ((x << 1) | 16'(op == OP_SHLC && ef[1])) & (b ? 16'h00ff : 16'hffff);
				ef = {r[k], r == 16'h0, x[k], b ? (x >= 16'h40 && x < 16'hc0) :
					(x >= 16'h4000 && x < 16'hc000)};
				q.push_back({ef, r});
			end
			default: ;
		endcase
	endtask

	// ==========
	// Tests
	initial
	begin
		clk_sys = 1'b0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		dly = 4'h0;
		bad_count = 0;
		check_count = 0;
		ef = 4'h0;
		esp = 20'h0;
		epc = 20'h0;
		emode = 3'h0;
		i = $urandom(32'h66cc);
		for (i = 0; i < 256; i++)
			mem_i.mem[i] = 16'($urandom);
		repeat (2) @(negedge clk_sys);
		rst_n = 1'b1;
		settle();
		for (i = 0; i < 8; i++)
			run(OP_COPY, i % 2, 16'($urandom), 16'h0);
		run(OP_IDLE, 0, 16'h0, 16'h0);
		settle();
		$display("test copy done");
		for (j = 0; j < 3; j++)
			for (i = 0; i < 12; i++)
				for (b = 0; b < 2; b++)
					run(ops[j], b, 16'h0, i < 10 ? tv[i] : 16'($urandom));
		settle();
		$display("test shift done");
		for (j = 0; j < 2; j++)
		begin
			dly = j ? 4'h3 : 4'h0;
			for (b = 0; b < 2; b++)
			begin
				s = 16'($urandom);
				run(OP_PUSH, b, s, 16'h0);
				settle();
				compare(32'(mem_i.mem[esp[8:1]]), 32'(b ? {8'h00, s[7:0]} : s));
			end
			run(OP_PULL, 1, 16'h0, 16'h0);
			run(OP_PULL, 0, 16'h0, 16'h0);
			settle();
		end
		$display("test stack done");
		dly = 4'h2;
		for (j = 0; j < 3; j++)
		begin
			mem_i.mem[esp[8:1]] = j ? 16'($urandom) | 16'h8000 : 16'hf13f;
			mem_i.mem[esp[8:1] + 8'h1] = 16'($urandom);
			run(OP_IRQ_EXIT, 0, 16'h0, 16'h0);
			settle();
			for (i = 0; i < 4; i++)
				run(ops[i % 3], i % 2, 16'($urandom), 16'($urandom));
			run(OP_PUSH, 0, 16'($urandom), 16'h0);
			run(OP_SUB_EXIT, 0, 16'h0, 16'h0);
			settle();
		end
		$display("test return done");
		complete_run();
	end

	// A hang ends the run here; the tests need far fewer cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		bad_count++;
		complete_run();
	end
endmodule
